// ==== tb/srel_ctrl_model.sv ====
// bus controller model issuing parsed commands and collecting answers
`timescale 1ns/1ps
module srel_ctrl_model (
  // clock
  input  wire logic                                core_clk_i,
  // answers from the block
  input  wire logic                                rsp_valid_i,
  input  wire logic [srel_pkg::GRP_W-1:0]          rsp_data_i,
  input  wire logic                                err_valid_i,
  // commands to the block
  output logic                                     cmd_valid_o,
  output srel_pkg::srel_cmd_t                      cmd_code_o,
  output srel_pkg::srel_grp_t                      cmd_group_o,
  output logic signed [srel_pkg::VALUE_W-1:0]      cmd_value_o
);
  import srel_pkg::*;
  logic             rsp_seen;
  logic [GRP_W-1:0] rsp_word;
  logic             err_seen;

  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o  = CMD_NONE;
    cmd_group_o = GRP_OPER;
    cmd_value_o = 32'sh0;
  end

  // mask values stay in 0..255 unless a scenario wants a refusal
  task automatic issue(input srel_cmd_t c, input srel_grp_t g, input logic signed [VALUE_W-1:0] v);
    @(posedge core_clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_code_o  = c;
    cmd_group_o = g;
    cmd_value_o = v;
    @(posedge core_clk_i);
    #1;
    rsp_seen    = rsp_valid_i;
    rsp_word    = rsp_data_i;
    err_seen    = err_valid_i;
    cmd_valid_o = 1'b0;
    cmd_code_o  = CMD_NONE;
    // released value lines differ from the last command
    cmd_value_o = ~cmd_value_o;
  endtask : issue
endmodule : srel_ctrl_model

// ==== tb/srel_sva.sv ====
// port-level assertions for the service request enable logic
`timescale 1ns/1ps
module srel_sva
  import srel_pkg::*;
(
  input wire logic                                core_clk_i,
  input wire logic                                rstn_i,
  input wire logic                                ce_i,
  input wire logic                                cmd_valid_i,
  input wire srel_pkg::srel_cmd_t                 cmd_code_i,
  input wire logic signed [srel_pkg::VALUE_W-1:0] cmd_value_i,
  input wire logic                                msg_avail_i,
  input wire logic                                rsp_valid_o,
  input wire logic [srel_pkg::GRP_W-1:0]          rsp_data_o,
  input wire logic                                err_valid_o,
  input wire logic [srel_pkg::GRP_W-1:0]          err_code_o,
  input wire logic                                srq_o,
  input wire logic [srel_pkg::MASK_W-1:0]         status_byte_o,
  input wire logic [srel_pkg::MASK_W-1:0]         srq_enable_mask_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  logic       take;
  logic       bad;
  logic [7:0] val8;
  assign take = cmd_valid_i && ce_i;
  assign bad  = (cmd_value_i < VALUE_MIN) || (cmd_value_i > VALUE_MAX);
  assign val8 = cmd_value_i[7:0];

  property p_bit6_zero;
    srq_enable_mask_o[STB_RQS] == 1'b0;
  endproperty
  a_bit6_zero: assert property (p_bit6_zero)
    else $error("mask bit 6 set");

  property p_mask_set;
    take && cmd_code_i == CMD_SRQ_MASK_SET && !bad |=> srq_enable_mask_o == ($past(val8) & MASK_WR_BITS);
  endproperty
  a_mask_set: assert property (p_mask_set)
    else $error("mask write wrong");

  property p_range;
    take && cmd_code_i == CMD_SRQ_MASK_SET && bad
      |=> err_valid_o && !rsp_valid_o && err_code_o == ERR_DATA_RANGE && $stable(srq_enable_mask_o);
  endproperty
  a_range: assert property (p_range)
    else $error("bad write not refused");

  property p_query;
    take && cmd_code_i == CMD_SRQ_MASK_QUERY |=> rsp_valid_o && rsp_data_o == {8'h00, srq_enable_mask_o};
  endproperty
  a_query: assert property (p_query)
    else $error("mask query answer wrong");

  property p_srq;
    $stable(srq_enable_mask_o) |-> srq_o == |(status_byte_o & srq_enable_mask_o & MASK_WR_BITS);
  endproperty
  a_srq: assert property (p_srq)
    else $error("request not OR of masked bits");

  property p_rqs;
    $rose(srq_o) |-> status_byte_o[STB_RQS];
  endproperty
  a_rqs: assert property (p_rqs)
    else $error("request flag not set");

  property p_poll;
    take && cmd_code_i == CMD_SERIAL_POLL |=> rsp_valid_o && rsp_data_o == {8'h00, $past(status_byte_o)}
      && status_byte_o[STB_RQS] == $rose(srq_o);
  endproperty
  a_poll: assert property (p_poll)
    else $error("serial poll wrong");

  property p_unused;
    status_byte_o[STB_UNUSED] == 1'b0;
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused status bit set");

  property p_mav;
    ce_i && $rose(msg_avail_i) |-> ##[1:2] status_byte_o[STB_MAV];
  endproperty
  a_mav: assert property (p_mav)
    else $error("message available not shown");
endmodule : srel_sva

bind srel_top srel_sva chk_u (.core_clk_i, .rstn_i, .ce_i, .cmd_valid_i, .cmd_code_i, .cmd_value_i,
  .msg_avail_i, .rsp_valid_o, .rsp_data_o, .err_valid_o, .err_code_o, .srq_o, .status_byte_o,
  .srq_enable_mask_o);

// ==== tb/testbench.sv ====
// self-checking bench for the service request enable logic
`timescale 1ns/1ps
module testbench;
  import srel_pkg::*;
  logic                      core_clk_i;
  logic                      rstn_i;
  logic                      ce_i;
  logic                      cmd_valid_i;
  srel_cmd_t                 cmd_code_i;
  srel_grp_t                 cmd_group_i;
  logic signed [VALUE_W-1:0] cmd_value_i;
  logic [GRP_W-1:0]          oper_cond_i;
  logic [GRP_W-1:0]          ques_cond_i;
  logic [GRP_W-1:0]          first_hw_status_group_cond_i;
  logic [GRP_W-1:0]          second_hw_status_group_cond_i;
  logic [CAL_W-1:0]          cal_cond_i;
  logic [MASK_W-1:0]         std_event_set_i;
  logic                      msg_avail_i;
  logic                      rsp_valid_o;
  logic [GRP_W-1:0]          rsp_data_o;
  logic                      err_valid_o;
  logic [GRP_W-1:0]          err_code_o;
  logic                      srq_o;
  logic [MASK_W-1:0]         status_byte_o;
  logic [MASK_W-1:0]         srq_enable_mask_o;
  int                        fails;
  int                        samples_checked;
  int                        cycles;

  srel_top dut_u (.core_clk_i, .rstn_i, .ce_i, .cmd_valid_i, .cmd_code_i, .cmd_group_i, .cmd_value_i,
    .oper_cond_i, .ques_cond_i, .first_hw_status_group_cond_i, .second_hw_status_group_cond_i,
    .cal_cond_i, .std_event_set_i, .msg_avail_i, .rsp_valid_o, .rsp_data_o, .err_valid_o,
    .err_code_o, .srq_o, .status_byte_o, .srq_enable_mask_o);

  srel_ctrl_model ctl_u (.core_clk_i, .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o),
    .err_valid_i(err_valid_o), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
    .cmd_group_o(cmd_group_i), .cmd_value_o(cmd_value_i));

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic finish_test();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // a hang counts as a mismatch
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("CHECK FAILED %0t timeout", $time);
      finish_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic cmd(input srel_cmd_t c, input srel_grp_t g, input logic signed [31:0] v);
    ctl_u.issue(c, g, v);
  endtask : cmd

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc

  task automatic set_cond(input int i, input logic [15:0] v);
    case (i)
      0: oper_cond_i = v;
      1: first_hw_status_group_cond_i = v;
      default: second_hw_status_group_cond_i = v;
    endcase
  endtask : set_cond

  task automatic t_mask();
    logic [7:0] wr [4] = '{8'hFF, 8'h12, 8'h40, 8'h00};
    logic [7:0] ex [4] = '{8'hBF, 8'h12, 8'h00, 8'h00};
    cmd(CMD_SRQ_MASK_QUERY, GRP_OPER, 32'sh0);
    chk(16'(ctl_u.rsp_seen), 16'h0001, "query answer");
    chk(ctl_u.rsp_word, 16'h0000, "mask reset");
    for (int k = 0; k < 4; k++) begin
      cmd(CMD_SRQ_MASK_SET, GRP_OPER, 32'(wr[k]));
      cmd(CMD_SRQ_MASK_QUERY, GRP_OPER, 32'sh0);
      chk(ctl_u.rsp_word, 16'(ex[k]), "mask readback");
    end
  endtask : t_mask

  task automatic t_range();
    logic signed [31:0] bad [2] = '{32'shFFFFFFFF, 32'sh100};
    cmd(CMD_SRQ_MASK_SET, GRP_OPER, 32'sh12);
    ce_i = 1'b0;
    cmd(CMD_SRQ_MASK_SET, GRP_OPER, 32'sh34);
    ce_i = 1'b1;
    chk(16'(srq_enable_mask_o), 16'h0012, "ce freeze");
    foreach (bad[k]) begin
      cmd(CMD_SRQ_MASK_SET, GRP_OPER, bad[k]);
      chk({15'h0, ctl_u.err_seen}, 16'h0001, "range error");
      chk(err_code_o, 16'hFF22, "error code");
      chk(16'(srq_enable_mask_o), 16'h0012, "mask kept");
    end
    cmd(CMD_STD_EVENT_QUERY, GRP_OPER, 32'sh0);
    chk(ctl_u.rsp_word, 16'h0010, "execution error");
    cmd(CMD_SRQ_MASK_SET, GRP_OPER, 32'sh0);
  endtask : t_range

  task automatic t_mav();
    cmd(CMD_CLEAR_STATUS, GRP_OPER, 32'sh0);
    cmd(CMD_SRQ_MASK_SET, GRP_OPER, 32'sh10);
    msg_avail_i = 1'b1;
    cyc(2);
    chk(16'(srq_o), 16'h0001, "mav request");
    chk(16'(status_byte_o), 16'h0050, "mav status");
    cmd(CMD_SERIAL_POLL, GRP_OPER, 32'sh0);
    chk(ctl_u.rsp_word, 16'h0050, "poll answer");
    chk(16'(status_byte_o), 16'h0010, "rqs cleared");
    cmd(CMD_STB_QUERY, GRP_OPER, 32'sh0);
    chk(ctl_u.rsp_word, 16'h0050, "mss bit");
    cmd(CMD_SRQ_MASK_SET, GRP_OPER, 32'sh0);
    cyc(1);
    chk(16'(srq_o), 16'h0000, "zero mask");
    msg_avail_i = 1'b0;
  endtask : t_mav

  task automatic t_groups();
    srel_grp_t gs [3] = '{GRP_OPER, GRP_FIRST_HW, GRP_SECOND_HW};
    int bits [3] = '{STB_OPER, STB_HW1, STB_HW2};
    for (int i = 0; i < 3; i++) begin
      cmd(CMD_CLEAR_STATUS, GRP_OPER, 32'sh0);
      cmd(CMD_GRP_PTR_SET, gs[i], 32'sh1);
      cmd(CMD_GRP_NTR_SET, gs[i], 32'sh0);
      cmd(CMD_GRP_ENAB_SET, gs[i], 32'sh1);
      cmd(CMD_SRQ_MASK_SET, GRP_OPER, 32'sh1 << bits[i]);
      set_cond(i, 16'h0001);
      cyc(2);
      chk(16'(status_byte_o & 8'hBF), 16'h0001 << bits[i], "summary bit");
      chk(16'(srq_o), 16'h0001, "group request");
      cmd(CMD_GRP_EVENT_QUERY, gs[i], 32'sh0);
      chk(ctl_u.rsp_word, 16'h0001, "event latched");
      cyc(2);
      chk(16'(srq_o), 16'h0000, "read clears");
      set_cond(i, 16'h0000);
      cmd(CMD_GRP_PTR_SET, gs[i], 32'sh0);
      cmd(CMD_GRP_EVENT_QUERY, gs[i], 32'sh0);
      chk(ctl_u.rsp_word, 16'h0000, "fall filtered");
      cmd(CMD_GRP_NTR_SET, gs[i], 32'sh1);
      set_cond(i, 16'h0001);
      cyc(2);
      set_cond(i, 16'h0000);
      cyc(2);
      cmd(CMD_GRP_EVENT_QUERY, gs[i], 32'sh0);
      chk(ctl_u.rsp_word, 16'h0001, "fall latched");
    end
    cmd(CMD_SRQ_MASK_SET, GRP_OPER, 32'sh0);
  endtask : t_groups

  task automatic t_cal();
    cmd(CMD_CLEAR_STATUS, GRP_OPER, 32'sh0);
    cmd(CMD_GRP_PTR_SET, GRP_CAL, 32'sh1F);
    cmd(CMD_GRP_ENAB_SET, GRP_CAL, 32'sh1F);
    cmd(CMD_GRP_PTR_SET, GRP_QUES, 32'sh100);
    cmd(CMD_GRP_ENAB_SET, GRP_QUES, 32'sh100);
    cmd(CMD_SRQ_MASK_SET, GRP_OPER, 32'sh8);
    for (int j = 0; j < CAL_W; j++) begin
      cal_cond_i = 5'h01 << j;
      cyc(3);
      chk(16'(srq_o), 16'h0001, "cal request");
      cmd(CMD_GRP_EVENT_QUERY, GRP_CAL, 32'sh0);
      chk(ctl_u.rsp_word, 16'h0001 << j, "cal bit");
      cmd(CMD_GRP_EVENT_QUERY, GRP_QUES, 32'sh0);
      chk(ctl_u.rsp_word, 16'h0100, "ques bit 8");
      cal_cond_i = 5'h00;
      cyc(3);
      chk(16'(srq_o), 16'h0000, "cal cleared");
    end
    cmd(CMD_SRQ_MASK_SET, GRP_OPER, 32'sh0);
  endtask : t_cal

  task automatic t_esb();
    cmd(CMD_CLEAR_STATUS, GRP_OPER, 32'sh0);
    cmd(CMD_EVT_MASK_SET, GRP_OPER, 32'sh3C);
    cmd(CMD_SRQ_MASK_SET, GRP_OPER, 32'sh20);
    for (int b = 0; b < 6; b++) begin
      std_event_set_i = 8'h01 << b;
      cyc(1);
      std_event_set_i = 8'h00;
      cyc(2);
      // bits 0 and 1 latch but are not enabled
      chk(16'(srq_o), (b > 1) ? 16'h0001 : 16'h0000, "esb request");
      if (b % 2 == 0) begin
        cmd(CMD_STD_EVENT_QUERY, GRP_OPER, 32'sh0);
        chk(ctl_u.rsp_word, 16'h0001 << b, "event direct");
      end else begin
        cmd(CMD_CLEAR_STATUS, GRP_OPER, 32'sh0);
      end
      cyc(2);
      chk(16'(srq_o), 16'h0000, "events gone");
    end
  endtask : t_esb

  initial begin
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    rstn_i = 1'b0;
    ce_i = 1'b1;
    oper_cond_i = 16'h0000;
    ques_cond_i = 16'h0000;
    first_hw_status_group_cond_i = 16'h0000;
    second_hw_status_group_cond_i = 16'h0000;
    cal_cond_i = 5'h00;
    std_event_set_i = 8'h00;
    msg_avail_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
    rstn_i = 1'b1;
    t_mask();
    t_range();
    t_mav();
    t_groups();
    t_cal();
    t_esb();
    finish_test();
  end
endmodule : testbench

// ==== verilog/srel_pkg.sv ====
// constants and types shared by the service request enable logic
package srel_pkg;

  // widths
  localparam int MASK_W  = 8;
  localparam int GRP_W   = 16;
  localparam int CAL_W   = 5;
  localparam int VALUE_W = 32;
  localparam int NUM_GRP = 5;

  // status byte bit positions
  localparam int STB_OPER   = 7;
  localparam int STB_RQS    = 6;
  localparam int STB_ESB    = 5;
  localparam int STB_MAV    = 4;
  localparam int STB_QUES   = 3;
  localparam int STB_UNUSED = 2;
  localparam int STB_HW2    = 1;
  localparam int STB_HW1    = 0;

  // standard event status bit positions
  localparam int ESR_CMD_ERR = 5;
  localparam int ESR_EXE_ERR = 4;
  localparam int ESR_DEV_ERR = 3;
  localparam int ESR_QRY_ERR = 2;

  // calibration condition bit positions
  localparam int CAL_TX_AUTOZERO = 4;
  localparam int CAL_VOLTMETER   = 3;
  localparam int CAL_COUNTER     = 2;
  localparam int CAL_SAMPLER     = 1;
  localparam int CAL_SPECTRUM    = 0;

  // questionable condition bit fed by the calibration summary
  localparam int QUES_CAL_BIT = 8;

  // service request mask: bit 6 is never written
  localparam logic [MASK_W-1:0]  MASK_WR_BITS   = 8'hBF;
  localparam logic [MASK_W-1:0]  MASK_RESET     = 8'h00;
  localparam logic [MASK_W-1:0]  EVT_MASK_RESET = 8'h00;
  localparam logic [GRP_W-1:0]   GRP_RESET      = 16'h0000;
  localparam logic [GRP_W-1:0]   GRP_TOP_ZERO   = 16'h7FFF;

  // accepted value range for mask writes
  localparam logic signed [VALUE_W-1:0] VALUE_MIN = 32'sh00000000;
  localparam logic signed [VALUE_W-1:0] VALUE_MAX = 32'sh000000FF;

  // error code -222, data out of range, in two's complement
  localparam logic [GRP_W-1:0] ERR_DATA_RANGE = 16'hFF22;
  localparam logic [GRP_W-1:0] ERR_NONE       = 16'h0000;

  typedef enum logic [4:0] {
    CMD_NONE            = 5'h00,
    CMD_SRQ_MASK_SET    = 5'h01,
    CMD_SRQ_MASK_QUERY  = 5'h02,
    CMD_STB_QUERY       = 5'h03,
    CMD_SERIAL_POLL     = 5'h04,
    CMD_EVT_MASK_SET    = 5'h05,
    CMD_EVT_MASK_QUERY  = 5'h06,
    CMD_STD_EVENT_QUERY = 5'h07,
    CMD_CLEAR_STATUS    = 5'h08,
    CMD_GRP_COND_QUERY  = 5'h09,
    CMD_GRP_PTR_SET     = 5'h0A,
    CMD_GRP_PTR_QUERY   = 5'h0B,
    CMD_GRP_NTR_SET     = 5'h0C,
    CMD_GRP_NTR_QUERY   = 5'h0D,
    CMD_GRP_ENAB_SET    = 5'h0E,
    CMD_GRP_ENAB_QUERY  = 5'h0F,
    CMD_GRP_EVENT_QUERY = 5'h10
  } srel_cmd_t;

  typedef enum logic [2:0] {
    GRP_OPER      = 3'h0,
    GRP_QUES      = 3'h1,
    GRP_FIRST_HW  = 3'h2,
    GRP_SECOND_HW = 3'h3,
    GRP_CAL       = 3'h4
  } srel_grp_t;

endpackage : srel_pkg

// ==== verilog/srel_status_group.sv ====
// one status group: condition, transition filters, event and enable registers
`timescale 1ns/1ps
module srel_status_group (
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rstn_i,
  input  wire logic                      ce_i,
  // live conditions
  input  wire logic [srel_pkg::GRP_W-1:0] cond_i,
  // configuration and access strobes
  input  wire logic                      clear_i,
  input  wire logic                      ptr_wr_i,
  input  wire logic                      ntr_wr_i,
  input  wire logic                      enab_wr_i,
  input  wire logic                      event_rd_i,
  input  wire logic [srel_pkg::GRP_W-1:0] wdata_i,
  // register contents and summary
  output logic      [srel_pkg::GRP_W-1:0] cond_o,
  output logic      [srel_pkg::GRP_W-1:0] ptr_o,
  output logic      [srel_pkg::GRP_W-1:0] ntr_o,
  output logic      [srel_pkg::GRP_W-1:0] enab_o,
  output logic      [srel_pkg::GRP_W-1:0] event_o,
  output logic                           summary_o
);
  import srel_pkg::*;

  logic [GRP_W-1:0] cond_reg,  cond_next;
  logic [GRP_W-1:0] ptr_reg,   ptr_next;
  logic [GRP_W-1:0] ntr_reg,   ntr_next;
  logic [GRP_W-1:0] enab_reg,  enab_next;
  logic [GRP_W-1:0] event_reg, event_next;
  logic [GRP_W-1:0] passed;

  always_comb begin
    cond_next = cond_i & GRP_TOP_ZERO;
    // only edges whose direction is enabled reach the event register
    passed    = (cond_next & ~cond_reg & ptr_reg) | (~cond_next & cond_reg & ntr_reg);
    ptr_next  = ptr_wr_i  ? (wdata_i & GRP_TOP_ZERO) : ptr_reg;
    ntr_next  = ntr_wr_i  ? (wdata_i & GRP_TOP_ZERO) : ntr_reg;
    enab_next = enab_wr_i ? (wdata_i & GRP_TOP_ZERO) : enab_reg;
    event_next = event_reg;
    if (clear_i || event_rd_i) begin
      event_next = GRP_RESET;
    end
    // a stale event register latches nothing new; a read frees it in the same cycle
    if ((event_reg == GRP_RESET) || clear_i || event_rd_i) begin
      event_next = event_next | passed;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cond_reg  <= GRP_RESET;
      ptr_reg   <= GRP_RESET;
      ntr_reg   <= GRP_RESET;
      enab_reg  <= GRP_RESET;
      event_reg <= GRP_RESET;
    end else if (ce_i) begin
      cond_reg  <= cond_next;
      ptr_reg   <= ptr_next;
      ntr_reg   <= ntr_next;
      enab_reg  <= enab_next;
      event_reg <= event_next;
    end
  end

  assign cond_o    = cond_reg;
  assign ptr_o     = ptr_reg;
  assign ntr_o     = ntr_reg;
  assign enab_o    = enab_reg;
  assign event_o   = event_reg;
  assign summary_o = |(event_reg & enab_reg);

endmodule : srel_status_group

// ==== verilog/srel_top.sv ====
// status byte, service request enable mask and service request generation
//
// Overview of operation
// - eight-bit mask selects status byte summaries
// - mask query returns value 0 to 255
// - mask write ignores bit 6
// - reject values outside 0..255, report -222
// - writing zero disables all service requests
// - request service when enabled summary bit true
// - transition filters choose which edges latch
// - summary true when enabled event latched
// - standard event bits set events directly
// - bit 4 message available, bit 1 second hardware
// - calibration summary drives questionable condition bit 8
// - standard event error bits gated by mask
// - five calibration self-test failure condition bits
// - clear-status empties all event registers
// - bit 6 set on request, poll clears
// - bits 7,5,3,1,0 summaries, bit 2 unused
// - reading clears events; stale register latches nothing
`timescale 1ns/1ps
module srel_top (
  // clock, enable and reset
  input  wire logic                             core_clk_i,
  input  wire logic                             rstn_i,
  input  wire logic                             ce_i,
  // parsed common and status commands
  input  wire logic                             cmd_valid_i,
  input  wire srel_pkg::srel_cmd_t              cmd_code_i,
  input  wire srel_pkg::srel_grp_t              cmd_group_i,
  input  wire logic signed [srel_pkg::VALUE_W-1:0] cmd_value_i,
  // instrument conditions
  input  wire logic [srel_pkg::GRP_W-1:0]        oper_cond_i,
  input  wire logic [srel_pkg::GRP_W-1:0]        ques_cond_i,
  input  wire logic [srel_pkg::GRP_W-1:0]        first_hw_status_group_cond_i,
  input  wire logic [srel_pkg::GRP_W-1:0]        second_hw_status_group_cond_i,
  input  wire logic [srel_pkg::CAL_W-1:0]        cal_cond_i,
  input  wire logic [srel_pkg::MASK_W-1:0]       std_event_set_i,
  input  wire logic                             msg_avail_i,
  // query answers into the output queue
  output logic                                  rsp_valid_o,
  output logic      [srel_pkg::GRP_W-1:0]        rsp_data_o,
  // error report
  output logic                                  err_valid_o,
  output logic      [srel_pkg::GRP_W-1:0]        err_code_o,
  // service request and status
  output logic                                  srq_o,
  output logic      [srel_pkg::MASK_W-1:0]       status_byte_o,
  output logic      [srel_pkg::MASK_W-1:0]       srq_enable_mask_o
);
  import srel_pkg::*;

  // true when a signed value fits the accepted mask range
  function automatic logic value_in_range(input logic signed [VALUE_W-1:0] v);
    value_in_range = (v >= VALUE_MIN) && (v <= VALUE_MAX);
  endfunction : value_in_range

  // one-hot group select for a group command
  function automatic logic [NUM_GRP-1:0] group_hit(input logic hit, input srel_grp_t g);
    group_hit = '0;
    if (hit) begin
      group_hit[g] = 1'b1;
    end
  endfunction : group_hit

  // command decode
  logic                 mask_cmd;
  logic                 range_ok;
  logic                 clear_status;
  logic [NUM_GRP-1:0]   ptr_wr;
  logic [NUM_GRP-1:0]   ntr_wr;
  logic [NUM_GRP-1:0]   enab_wr;
  logic [NUM_GRP-1:0]   event_rd;
  logic [GRP_W-1:0]     wdata;

  // group wiring
  logic [GRP_W-1:0]     grp_cond_in [NUM_GRP];
  logic [GRP_W-1:0]     grp_cond    [NUM_GRP];
  logic [GRP_W-1:0]     grp_ptr     [NUM_GRP];
  logic [GRP_W-1:0]     grp_ntr     [NUM_GRP];
  logic [GRP_W-1:0]     grp_enab    [NUM_GRP];
  logic [GRP_W-1:0]     grp_event   [NUM_GRP];
  logic [NUM_GRP-1:0]   grp_summary;

  // registers and next values
  logic [MASK_W-1:0]    srq_mask_reg,   srq_mask_next;
  logic [MASK_W-1:0]    evt_mask_reg,   evt_mask_next;
  logic [MASK_W-1:0]    std_event_reg,  std_event_next;
  logic [MASK_W-1:0]    stb_reg,        stb_next;
  logic                 rqs_reg,        rqs_next;
  logic                 srq_reg,        srq_next;
  logic                 rsp_valid_reg,  rsp_valid_next;
  logic [GRP_W-1:0]     rsp_data_reg,   rsp_data_next;
  logic                 err_valid_reg,  err_valid_next;
  logic [GRP_W-1:0]     err_code_reg,   err_code_next;
  logic [MASK_W-1:0]    summaries;
  logic                 mss;
  logic                 range_err;

  // decode
  always_comb begin
    mask_cmd     = (cmd_code_i == CMD_SRQ_MASK_SET) || (cmd_code_i == CMD_EVT_MASK_SET);
    range_ok     = value_in_range(cmd_value_i);
    range_err    = cmd_valid_i && mask_cmd && !range_ok;
    clear_status = cmd_valid_i && (cmd_code_i == CMD_CLEAR_STATUS);
    wdata        = cmd_value_i[GRP_W-1:0];
    ptr_wr       = group_hit(cmd_valid_i && (cmd_code_i == CMD_GRP_PTR_SET), cmd_group_i);
    ntr_wr       = group_hit(cmd_valid_i && (cmd_code_i == CMD_GRP_NTR_SET), cmd_group_i);
    enab_wr      = group_hit(cmd_valid_i && (cmd_code_i == CMD_GRP_ENAB_SET), cmd_group_i);
    event_rd     = group_hit(cmd_valid_i && (cmd_code_i == CMD_GRP_EVENT_QUERY), cmd_group_i);
  end

  // condition sources; calibration summary lands in questionable bit 8
  always_comb begin
    grp_cond_in[GRP_OPER]      = oper_cond_i;
    grp_cond_in[GRP_QUES]      = ques_cond_i;
    grp_cond_in[GRP_QUES][QUES_CAL_BIT] = grp_summary[GRP_CAL];
    grp_cond_in[GRP_FIRST_HW]  = first_hw_status_group_cond_i;
    grp_cond_in[GRP_SECOND_HW] = second_hw_status_group_cond_i;
    grp_cond_in[GRP_CAL]       = GRP_RESET;
    grp_cond_in[GRP_CAL][CAL_W-1:0] = cal_cond_i;
  end

  for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
    srel_status_group u_grp (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .ce_i       (ce_i),
      .cond_i     (grp_cond_in[g]),
      .clear_i    (clear_status),
      .ptr_wr_i   (ptr_wr[g]),
      .ntr_wr_i   (ntr_wr[g]),
      .enab_wr_i  (enab_wr[g]),
      .event_rd_i (event_rd[g]),
      .wdata_i    (wdata),
      .cond_o     (grp_cond[g]),
      .ptr_o      (grp_ptr[g]),
      .ntr_o      (grp_ntr[g]),
      .enab_o     (grp_enab[g]),
      .event_o    (grp_event[g]),
      .summary_o  (grp_summary[g])
    );
  end

  // masks and standard event register
  always_comb begin
    srq_mask_next = srq_mask_reg;
    evt_mask_next = evt_mask_reg;
    if (cmd_valid_i && (cmd_code_i == CMD_SRQ_MASK_SET) && range_ok) begin
      // bit 6 keeps its old value, which is always zero; a zero write disables all requests
      srq_mask_next = (cmd_value_i[MASK_W-1:0] & MASK_WR_BITS) | (srq_mask_reg & ~MASK_WR_BITS);
    end
    if (cmd_valid_i && (cmd_code_i == CMD_EVT_MASK_SET) && range_ok) begin
      evt_mask_next = cmd_value_i[MASK_W-1:0];
    end
    std_event_next = std_event_reg;
    if (clear_status || (cmd_valid_i && (cmd_code_i == CMD_STD_EVENT_QUERY))) begin
      std_event_next = EVT_MASK_RESET;
    end
    // no filters here: set inputs go straight in, but only while the register is free
    if ((std_event_reg == EVT_MASK_RESET) || (std_event_next == EVT_MASK_RESET)) begin
      std_event_next = std_event_next | std_event_set_i;
      std_event_next[ESR_EXE_ERR] = std_event_next[ESR_EXE_ERR] | range_err;
    end
  end

  // status byte and service request
  always_comb begin
    summaries             = '0;
    summaries[STB_OPER]   = grp_summary[GRP_OPER];
    summaries[STB_ESB]    = |(std_event_reg & evt_mask_reg);
    summaries[STB_MAV]    = msg_avail_i;
    summaries[STB_QUES]   = grp_summary[GRP_QUES];
    summaries[STB_UNUSED] = 1'b0;
    summaries[STB_HW2]    = grp_summary[GRP_SECOND_HW];
    summaries[STB_HW1]    = grp_summary[GRP_FIRST_HW];
    mss      = |(summaries & srq_mask_reg & MASK_WR_BITS);
    srq_next = mss;
    // a fresh request sets the flag; the set wins over a poll in the same cycle
    rqs_next = rqs_reg;
    if (cmd_valid_i && (cmd_code_i == CMD_SERIAL_POLL)) begin
      rqs_next = 1'b0;
    end
    if (mss && !srq_reg) begin
      rqs_next = 1'b1;
    end
    stb_next          = summaries;
    stb_next[STB_RQS] = rqs_next;
  end

  // answers and errors
  always_comb begin
    rsp_valid_next = 1'b0;
    rsp_data_next  = rsp_data_reg;
    err_valid_next = range_err;
    err_code_next  = range_err ? ERR_DATA_RANGE : err_code_reg;
    if (cmd_valid_i) begin
      rsp_valid_next = 1'b1;
      case (cmd_code_i)
        CMD_SRQ_MASK_QUERY:  rsp_data_next = {{(GRP_W-MASK_W){1'b0}}, srq_mask_reg};
        CMD_STB_QUERY:       rsp_data_next = {{(GRP_W-MASK_W){1'b0}}, summaries[MASK_W-1:STB_RQS+1],
                                              mss, summaries[STB_RQS-1:0]};
        CMD_SERIAL_POLL:     rsp_data_next = {{(GRP_W-MASK_W){1'b0}}, stb_reg};
        CMD_EVT_MASK_QUERY:  rsp_data_next = {{(GRP_W-MASK_W){1'b0}}, evt_mask_reg};
        CMD_STD_EVENT_QUERY: rsp_data_next = {{(GRP_W-MASK_W){1'b0}}, std_event_reg};
        CMD_GRP_COND_QUERY:  rsp_data_next = grp_cond[cmd_group_i];
        CMD_GRP_PTR_QUERY:   rsp_data_next = grp_ptr[cmd_group_i];
        CMD_GRP_NTR_QUERY:   rsp_data_next = grp_ntr[cmd_group_i];
        CMD_GRP_ENAB_QUERY:  rsp_data_next = grp_enab[cmd_group_i];
        CMD_GRP_EVENT_QUERY: rsp_data_next = grp_event[cmd_group_i];
        default: begin
          rsp_valid_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      srq_mask_reg  <= MASK_RESET;
      evt_mask_reg  <= EVT_MASK_RESET;
      std_event_reg <= EVT_MASK_RESET;
      stb_reg       <= MASK_RESET;
      rqs_reg       <= 1'b0;
      srq_reg       <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= GRP_RESET;
      err_valid_reg <= 1'b0;
      err_code_reg  <= ERR_NONE;
    end else if (ce_i) begin
      srq_mask_reg  <= srq_mask_next;
      evt_mask_reg  <= evt_mask_next;
      std_event_reg <= std_event_next;
      stb_reg       <= stb_next;
      rqs_reg       <= rqs_next;
      srq_reg       <= srq_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_data_reg  <= rsp_data_next;
      err_valid_reg <= err_valid_next;
      err_code_reg  <= err_code_next;
    end
  end

  assign rsp_valid_o       = rsp_valid_reg;
  assign rsp_data_o        = rsp_data_reg;
  assign err_valid_o       = err_valid_reg;
  assign err_code_o        = err_code_reg;
  assign srq_o             = srq_reg;
  assign status_byte_o     = stb_reg;
  assign srq_enable_mask_o = srq_mask_reg;

endmodule : srel_top
